/* File: pwm_auto_shutdown_control.sv */
// auto-shutdown control of the enhanced pwm unit with ahb-lite registers
//
// Notes on behaviour
// [RULE_01] selected event sets flag; flag high forces outputs to shutdown state
// [RULE_02] source select 000 disables auto-shutdown; a software write can still set flag
// [RULE_03] 001 comparator one, 010 comparator two, 011 either comparator high
// [RULE_04] 100 shuts down only on low fault pin
// [RULE_05] 101/110/111 low fault pin or comparator one/two/either high
// [RULE_06] pair a/c: 1x tri-state, 01 drive high, 00 drive low
// [RULE_07] pair b/d: 1x tri-state, 01 drive high, 00 drive low
// [RULE_08] condition is level-based; shutdown lasts while level present
// [RULE_09] software writes to flag ignored while condition present
// [RULE_10] auto-restart clears flag when event goes; else software clears
// [RULE_11] pwm resumes only at start of next pwm period
// [RULE_12] fault and comparator inputs are two-flop synchronised first
`timescale 1ns/1ns
`default_nettype none
module pwm_auto_shutdown_control #(
  parameter int unsigned PERIOD_W = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        fault_input_pin_n,
  input  wire logic        comparator_one_output,
  input  wire logic        comparator_two_output,
  input  wire logic [3:0]  pwm_drive,
  output var  logic        pwm_output_a,
  output var  logic        pwm_output_a_oe_n,
  output var  logic        pwm_output_b,
  output var  logic        pwm_output_b_oe_n,
  output var  logic        pwm_output_c,
  output var  logic        pwm_output_c_oe_n,
  output var  logic        pwm_output_d,
  output var  logic        pwm_output_d_oe_n,
  output var  logic        period_start,
  output var  logic        irq
);
  typedef enum logic [1:0] {RUN, SHUT, WAIT_PERIOD} sd_state_t;

  pwm_shutdown_pkg::shutdown_ctrl_t ctrl_r;
  pwm_shutdown_pkg::shutdown_src_t  src_async;
  pwm_shutdown_pkg::shutdown_src_t  src_sync;
  sd_state_t                        state_r;
  sd_state_t                        state_nxt;
  logic                             restart_en_r;
  logic [PERIOD_W-1:0]              period_r;
  logic [PERIOD_W-1:0]              cnt_r;
  logic [pwm_shutdown_pkg::IRQ_W-1:0] irq_stat_r;
  logic [pwm_shutdown_pkg::IRQ_W-1:0] irq_mask_r;
  logic [pwm_shutdown_pkg::IRQ_W-1:0] irq_set;
  logic                             wr_pend_r;
  logic [7:0]                       wr_addr_r;
  logic                             flag_nxt;

  // pin sampling, fault idles high
  assign src_async = '{fault_n: fault_input_pin_n, cmp_one: comparator_one_output,
                       cmp_two: comparator_two_output};
  sync_pair #(.W(3), .INIT(3'h4)) u_sync ( // [RULE_12]
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (src_async),
    .sync_out (src_sync)
  );

  // source decode: bit2 selects fault, bits1:0 select comparators
  function automatic logic shutdown_cond(input logic [2:0] sel, input pwm_shutdown_pkg::shutdown_src_t s);
    logic fault_hit;
    logic cmp_hit;
    fault_hit = sel[2] && !s.fault_n;                         // [RULE_04] [RULE_05]
    cmp_hit   = (sel[0] && s.cmp_one) || (sel[1] && s.cmp_two); // [RULE_03] [RULE_05]
    return fault_hit || cmp_hit;                              // [RULE_02]
  endfunction

  wire cond = shutdown_cond(ctrl_r.src, src_sync); // [RULE_08]

  // bus decode
  wire        bus_req   = hsel && hready && (htrans == pwm_shutdown_pkg::HTRANS_NONSEQ) &&
                          (hsize == pwm_shutdown_pkg::HSIZE_WORD);
  wire        rd_req    = bus_req && !hwrite;
  wire [7:0]  req_off   = haddr[7:0];
  wire        wr_ctrl   = wr_pend_r && (wr_addr_r == pwm_shutdown_pkg::OFF_SHUTDOWN);
  wire        wr_rst    = wr_pend_r && (wr_addr_r == pwm_shutdown_pkg::OFF_RESTART);
  wire        wr_per    = wr_pend_r && (wr_addr_r == pwm_shutdown_pkg::OFF_PWM_PERIOD);
  wire        wr_mask   = wr_pend_r && (wr_addr_r == pwm_shutdown_pkg::OFF_IRQ_MASK);
  wire        rd_status = rd_req && (req_off == pwm_shutdown_pkg::OFF_IRQ_STATUS);
  wire        period_end = (cnt_r == period_r);

  // flag: hardware set wins; software write blocked while condition holds
  always_comb
  begin
    flag_nxt = ctrl_r.flag;
    if (wr_ctrl && !cond)                                    // [RULE_09]
      flag_nxt = hwdata[pwm_shutdown_pkg::BIT_FLAG];
    if (ctrl_r.flag && !cond && restart_en_r)                // [RULE_10]
      flag_nxt = 1'b0;
    if (cond)                                                // [RULE_01] [RULE_08]
      flag_nxt = 1'b1;
  end

  // output state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RUN:         if (flag_nxt) state_nxt = SHUT;
      SHUT:        if (!flag_nxt) state_nxt = WAIT_PERIOD;
      WAIT_PERIOD:
      begin
        if (flag_nxt)
          state_nxt = SHUT;
        else if (period_end)                                 // [RULE_11]
          state_nxt = RUN;
      end
      default:     state_nxt = RUN;
    endcase
  end

  assign irq_set[pwm_shutdown_pkg::IRQ_SHUTDOWN] = flag_nxt && !ctrl_r.flag;
  assign irq_set[pwm_shutdown_pkg::IRQ_RESUME]   = (state_r == WAIT_PERIOD) && (state_nxt == RUN);

  wire shut_now = (state_nxt != RUN);

  // pin drive per pair field
  function automatic logic [1:0] pin_out(input logic [1:0] pss, input logic pwm, input logic shut);
    if (!shut)
      return {pwm, 1'b0};
    else if (pss[1])
      return {1'b0, 1'b1};
    else
      return {pss == pwm_shutdown_pkg::PAIR_HIGH, 1'b0};
  endfunction

  wire [1:0] pa = pin_out(ctrl_r.ac, pwm_drive[0], shut_now); // [RULE_06]
  wire [1:0] pc = pin_out(ctrl_r.ac, pwm_drive[2], shut_now); // [RULE_06]
  wire [1:0] pb = pin_out(ctrl_r.bd, pwm_drive[1], shut_now); // [RULE_07]
  wire [1:0] pd = pin_out(ctrl_r.bd, pwm_drive[3], shut_now); // [RULE_07]

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (req_off)
      pwm_shutdown_pkg::OFF_SHUTDOWN:   rd_mux[7:0] = ctrl_r;
      pwm_shutdown_pkg::OFF_RESTART:    rd_mux[pwm_shutdown_pkg::BIT_RESTART] = restart_en_r;
      pwm_shutdown_pkg::OFF_PWM_PERIOD: rd_mux[PERIOD_W-1:0] = period_r;
      pwm_shutdown_pkg::OFF_IRQ_STATUS: rd_mux[pwm_shutdown_pkg::IRQ_W-1:0] = irq_stat_r;
      pwm_shutdown_pkg::OFF_IRQ_MASK:   rd_mux[pwm_shutdown_pkg::IRQ_W-1:0] = irq_mask_r;
      pwm_shutdown_pkg::OFF_PIN_STATE:  rd_mux[2:0] = src_sync;
      default:                          rd_mux = 32'h0;
    endcase
  end

  // bus phase tracking and read data
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0;
    end
    else
    begin
      wr_pend_r <= bus_req && hwrite;
      wr_addr_r <= req_off;
      if (rd_req)
        hrdata <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r       <= '{flag: 1'b0, src: pwm_shutdown_pkg::SRC_RESET,
                        ac: pwm_shutdown_pkg::PAIR_RESET, bd: pwm_shutdown_pkg::PAIR_RESET};
      restart_en_r <= 1'b0;
      period_r     <= PERIOD_W'(pwm_shutdown_pkg::PERIOD_RESET);
      irq_mask_r   <= '0;
    end
    else
    begin
      ctrl_r.flag <= flag_nxt;
      if (wr_ctrl)
      begin
        ctrl_r.src <= hwdata[pwm_shutdown_pkg::BIT_SRC_HI:pwm_shutdown_pkg::BIT_SRC_LO];
        ctrl_r.ac  <= hwdata[pwm_shutdown_pkg::BIT_AC_HI:pwm_shutdown_pkg::BIT_AC_LO];
        ctrl_r.bd  <= hwdata[pwm_shutdown_pkg::BIT_BD_HI:pwm_shutdown_pkg::BIT_BD_LO];
      end
      if (wr_rst)
        restart_en_r <= hwdata[pwm_shutdown_pkg::BIT_RESTART];
      if (wr_per)
        period_r <= hwdata[PERIOD_W-1:0];
      if (wr_mask)
        irq_mask_r <= hwdata[pwm_shutdown_pkg::IRQ_W-1:0];
    end
  end

  // period counter, state, sticky status; set wins over read-clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r      <= '0;
      state_r    <= RUN;
      irq_stat_r <= '0;
    end
    else
    begin
      cnt_r      <= period_end ? '0 : cnt_r + 1'b1;
      state_r    <= state_nxt;
      irq_stat_r <= (rd_status ? '0 : irq_stat_r) | irq_set;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_output_a      <= 1'b0;
      pwm_output_a_oe_n <= 1'b1;
      pwm_output_b      <= 1'b0;
      pwm_output_b_oe_n <= 1'b1;
      pwm_output_c      <= 1'b0;
      pwm_output_c_oe_n <= 1'b1;
      pwm_output_d      <= 1'b0;
      pwm_output_d_oe_n <= 1'b1;
      period_start      <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      {pwm_output_a, pwm_output_a_oe_n} <= pa;
      {pwm_output_b, pwm_output_b_oe_n} <= pb;
      {pwm_output_c, pwm_output_c_oe_n} <= pc;
      {pwm_output_d, pwm_output_d_oe_n} <= pd;
      period_start <= period_end;
      irq          <= |(((rd_status ? '0 : irq_stat_r) | irq_set) & irq_mask_r);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks
  property p_flag_set;
    @(posedge core_clk) disable iff (rst)
    cond |=> ctrl_r.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by condition"); // [RULE_01]

  property p_disabled;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.src == 3'h0) |-> !cond;
  endproperty
  a_disabled: assert property (p_disabled) else $error("shutdown with source disabled"); // [RULE_02]

  property p_cmp_one;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.src == 3'h1 && src_sync.cmp_one) |-> cond;
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("comparator one missed"); // [RULE_03]

  property p_fault_only;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.src == 3'h4) |-> (cond == !src_sync.fault_n);
  endproperty
  a_fault_only: assert property (p_fault_only) else $error("fault-only decode wrong"); // [RULE_04]

  property p_fault_or_two;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.src == 3'h6) |-> (cond == (!src_sync.fault_n || src_sync.cmp_two));
  endproperty
  a_fault_or_two: assert property (p_fault_or_two) else $error("fault or comparator two wrong"); // [RULE_05]

  property p_ac_tristate;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.flag && ctrl_r.ac[1] && $stable(ctrl_r.ac)) |=> (pwm_output_a_oe_n && pwm_output_c_oe_n);
  endproperty
  a_ac_tristate: assert property (p_ac_tristate) else $error("pair a/c not tri-stated"); // [RULE_06]

  property p_bd_high;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.flag && ctrl_r.bd == 2'h1 && $stable(ctrl_r.bd)) |=> (pwm_output_b && pwm_output_d && !pwm_output_b_oe_n);
  endproperty
  a_bd_high: assert property (p_bd_high) else $error("pair b/d not driven high"); // [RULE_07]

  property p_sw_blocked;
    @(posedge core_clk) disable iff (rst)
    (cond && ctrl_r.flag) |=> ctrl_r.flag;
  endproperty
  a_sw_blocked: assert property (p_sw_blocked) else $error("flag cleared under condition"); // [RULE_09]

  property p_auto_restart;
    @(posedge core_clk) disable iff (rst)
    (ctrl_r.flag && !cond && restart_en_r) |=> !ctrl_r.flag;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto-restart did not clear"); // [RULE_10]

  property p_resume_on_period;
    @(posedge core_clk) disable iff (rst)
    $rose(state_r == RUN) |-> $past(period_end);
  endproperty
  a_resume_on_period: assert property (p_resume_on_period) else $error("resumed mid-period"); // [RULE_11]

  property p_level_shut;
    @(posedge core_clk) disable iff (rst)
    (cond && ctrl_r.ac == pwm_shutdown_pkg::PAIR_LOW) |=> (!pwm_output_a && !pwm_output_a_oe_n && !pwm_output_c);
  endproperty
  a_level_shut: assert property (p_level_shut) else $error("pair a/c not held low under condition"); // [RULE_08]

  property p_sync_delay;
    @(posedge core_clk) disable iff (rst)
    src_sync == $past(src_async, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin levels not two flops late"); // [RULE_12]

  property p_irq_level;
    @(posedge core_clk) disable iff (rst)
    ((irq_stat_r & irq_mask_r) != '0 && $stable(irq_mask_r)) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt low with unmasked status"); // [RULE_01]

  property p_shut_status;
    @(posedge core_clk) disable iff (rst)
    (cond && !ctrl_r.flag) |=> irq_stat_r[pwm_shutdown_pkg::IRQ_SHUTDOWN];
  endproperty
  a_shut_status: assert property (p_shut_status) else $error("shutdown status bit not set"); // [RULE_01]

  property p_sw_clear;
    @(posedge core_clk) disable iff (rst)
    (wr_ctrl && !cond && !restart_en_r && !hwdata[pwm_shutdown_pkg::BIT_FLAG]) |=> !ctrl_r.flag;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear of flag lost"); // [RULE_10]
endmodule
`default_nettype wire

/* File: pwm_shutdown_pkg.sv */
// constants and carrier types for the pwm auto-shutdown block
package pwm_shutdown_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SHUTDOWN   = 8'h00;
  localparam logic [7:0] OFF_RESTART    = 8'h04;
  localparam logic [7:0] OFF_PWM_PERIOD = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFF_PIN_STATE  = 8'h14;
  // auto_shutdown_control field positions, then the restart enable bit of the restart register
  localparam int unsigned BIT_FLAG     = 7;
  localparam int unsigned BIT_SRC_HI   = 6;
  localparam int unsigned BIT_SRC_LO   = 4;
  localparam int unsigned BIT_AC_HI    = 3;
  localparam int unsigned BIT_AC_LO    = 2;
  localparam int unsigned BIT_BD_HI    = 1;
  localparam int unsigned BIT_BD_LO    = 0;
  localparam int unsigned BIT_RESTART  = 7;
  // interrupt status bits
  localparam int unsigned IRQ_SHUTDOWN = 0;
  localparam int unsigned IRQ_RESUME   = 1;
  localparam int unsigned IRQ_W        = 2;
  // reset values
  localparam logic [2:0]  SRC_RESET     = 3'h0;
  localparam logic [1:0]  PAIR_RESET    = 2'h0;
  localparam logic [15:0] PERIOD_RESET  = 16'h00ff;
  // pair shutdown state codes
  localparam logic [1:0]  PAIR_LOW  = 2'h0;
  localparam logic [1:0]  PAIR_HIGH = 2'h1;
  // ahb transfer codes
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic       flag;
    logic [2:0] src;
    logic [1:0] ac;
    logic [1:0] bd;
  } shutdown_ctrl_t;

  typedef struct packed {
    logic fault_n;
    logic cmp_one;
    logic cmp_two;
  } shutdown_src_t;
endpackage

/* File: sync_pair.sv */
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module sync_pair #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: fault_source_model.sv */
// far-side model: external fault pin and two comparators
`timescale 1ns/1ns
`default_nettype none
module fault_source_model #(
  parameter int unsigned SKEW = 3
) (
  input  wire logic core_clk,
  input  wire logic fault_req,
  input  wire logic cmp1_req,
  input  wire logic cmp2_req,
  output var  logic fault_input_pin_n,
  output var  logic comparator_one_output,
  output var  logic comparator_two_output
);
  initial {fault_input_pin_n, comparator_one_output, comparator_two_output} = 3'h4;
  // levels move SKEW (3 ns) after each sampling edge, within the high phase of the clock
  always @(posedge core_clk)
  begin
    fault_input_pin_n     <= #(SKEW) !fault_req;
    comparator_one_output <= #(SKEW) cmp1_req;
    comparator_two_output <= #(SKEW) cmp2_req;
  end
endmodule
`default_nettype wire

/* File: pwm_auto_shutdown_control_tb.sv */
// self-checking bench for the pwm auto-shutdown block
`timescale 1ns/1ns
`default_nettype none
module pwm_auto_shutdown_control_tb;
  logic        core_clk;
  logic        rst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        fault_req;
  logic        cmp1_req;
  logic        cmp2_req;
  logic        fault_n;
  logic        cmp_one;
  logic        cmp_two;
  logic [3:0]  pwm_drive;
  logic [3:0]  pin_v;
  logic [3:0]  pin_oe_n;
  logic        period_start;
  logic        irq;
  logic [8:0]  pm;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  integer      seed;
  logic [31:0] rq[$];
  logic [8:0]  pq[$];
  logic [8:0]  mq[$];
  event        rd_ev;
  event        pin_ev;

  pwm_auto_shutdown_control dut (
    .core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .fault_input_pin_n(fault_n), .comparator_one_output(cmp_one),
    .comparator_two_output(cmp_two), .pwm_drive(pwm_drive),
    .pwm_output_a(pin_v[0]), .pwm_output_a_oe_n(pin_oe_n[0]),
    .pwm_output_b(pin_v[1]), .pwm_output_b_oe_n(pin_oe_n[1]),
    .pwm_output_c(pin_v[2]), .pwm_output_c_oe_n(pin_oe_n[2]),
    .pwm_output_d(pin_v[3]), .pwm_output_d_oe_n(pin_oe_n[3]),
    .period_start(period_start), .irq(irq)
  );

  fault_source_model far (
    .core_clk(core_clk), .fault_req(fault_req), .cmp1_req(cmp1_req), .cmp2_req(cmp2_req),
    .fault_input_pin_n(fault_n), .comparator_one_output(cmp_one),
    .comparator_two_output(cmp_two)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one single ahb transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= pwm_shutdown_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    rq.push_back(e);
    ->rd_ev;
  endtask

  // tri-stated pins have no defined value, so their value bit is masked
  task automatic pins(input logic sd, input logic [1:0] ac, input logic [1:0] bd,
                      input logic [3:0] drv, input logic q);
    logic [3:0] oe;
    logic [3:0] v;
    oe = sd ? {bd[1], ac[1], bd[1], ac[1]} : 4'h0;
    v  = sd ? {bd[0], ac[0], bd[0], ac[0]} : drv;
    pq.push_back({q, oe, v});
    mq.push_back({5'h1f, ~oe});
    ->pin_ev;
  endtask

  always @(rd_ev) chk("hrdata", hrdata, rq.pop_front());

  always @(pin_ev)
  begin
    #1;
    pm = mq.pop_front();
    chk("pins", {23'h0, {irq, pin_oe_n, pin_v} & pm}, {23'h0, pq.pop_front() & pm});
  end

  // wait for the period wrap pulse, then realign to the edge
  task automatic wait_wrap();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (period_start !== 1'b1 && n < 40);
    chk("period_start", {31'h0, period_start}, 32'h1);
    @(posedge core_clk);
  endtask

  // k: 0 fault low, 1 comparator one high, 2 comparator two high
  task automatic run_case(input logic [2:0] src, input int k);
    logic        sd;
    logic [3:0]  drv;
    logic [3:0]  pr;
    logic [31:0] ctl;
    sd = (k == 0 && src[2]) || (k == 1 && src[0]) || (k == 2 && src[1]);
    drv = 4'($random(seed));
    pr = 4'($random(seed));
    ctl = {24'h0, 1'b0, src, pr};
    pwm_drive <= drv;
    bus(1'b1, pwm_shutdown_pkg::OFF_SHUTDOWN, ctl);
    {fault_req, cmp1_req, cmp2_req} <= {k == 0, k == 1, k == 2};
    repeat (6) @(posedge core_clk);
    pins(sd, pr[3:2], pr[1:0], drv, sd);
    rd(pwm_shutdown_pkg::OFF_SHUTDOWN, ctl | {sd, 7'h0});
    rd(pwm_shutdown_pkg::OFF_IRQ_STATUS, {31'h0, sd});
    bus(1'b1, pwm_shutdown_pkg::OFF_SHUTDOWN, ctl);
    rd(pwm_shutdown_pkg::OFF_SHUTDOWN, ctl | {sd, 7'h0});
    {fault_req, cmp1_req, cmp2_req} <= 3'h0;
    repeat (5) @(posedge core_clk);
    bus(1'b1, pwm_shutdown_pkg::OFF_SHUTDOWN, ctl);
    wait_wrap();
    @(posedge core_clk);
    pins(1'b0, pr[3:2], pr[1:0], drv, 1'b0);
    rd(pwm_shutdown_pkg::OFF_IRQ_STATUS, {30'h0, sd, 1'b0});
  endtask

  initial
  begin
    seed = 32'hb5d2;
    rst = 1'b1;
    {haddr, htrans, hwrite, hwdata} = '0;
    hsize = pwm_shutdown_pkg::HSIZE_WORD;
    {fault_req, cmp1_req, cmp2_req, pwm_drive} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(pwm_shutdown_pkg::OFF_SHUTDOWN, 32'h0);
    rd(pwm_shutdown_pkg::OFF_PWM_PERIOD, 32'hff);
    rd(pwm_shutdown_pkg::OFF_IRQ_MASK, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    bus(1'b1, pwm_shutdown_pkg::OFF_PWM_PERIOD, 32'hf);
    bus(1'b1, pwm_shutdown_pkg::OFF_IRQ_MASK, 32'h1);
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++)
        run_case(s[2:0], k);
    // auto-restart with a long-held fault level
    bus(1'b1, pwm_shutdown_pkg::OFF_RESTART, 32'h80);
    bus(1'b1, pwm_shutdown_pkg::OFF_SHUTDOWN, 32'h40);
    fault_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    pins(1'b1, 2'h0, 2'h0, 4'h0, 1'b1);
    fault_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(pwm_shutdown_pkg::OFF_SHUTDOWN, 32'h40);
    wait_wrap();
    @(posedge core_clk);
    pins(1'b0, 2'h0, 2'h0, pwm_drive, 1'b1);
    rd(pwm_shutdown_pkg::OFF_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge core_clk);
    end_of_test();
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
